// *** pcs_device.sv ***
module pcs_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Socket link
  pcs_link_if.dev link,
  // Socket side
  input wire logic power_fail_threshold,
  input wire logic osc_tick,
  output logic mem_ce_n,
  output logic osc_run
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic act;
    logic wr;
    logic din;
    logic [5:0] ptr;
    logic miss;
    logic open;
    logic [5:0] cnt;
    logic wbyte;
    logic dout;
    logic [63:0] regs;
    logic [63:0] shadow;
  } pcs_dev_s;

  pcs_dev_s st_ff;
  pcs_dev_s nxt_st;

  function automatic logic [7:0] pcs_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] pcs_days(input logic [7:0] m,
                                          input logic [7:0] y);
    logic leap;
    leap = (~y[4] & (y[3:0] == 4'h0 | y[3:0] == 4'h4 | y[3:0] == 4'h8))
         | (y[4] & (y[3:0] == 4'h2 | y[3:0] == 4'h6));
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // One hundredth-second step of the BCD calendar
  function automatic logic [63:0] pcs_advance(input logic [63:0] r);
    logic [63:0] n;
    logic c;
    logic [7:0] h;
    logic [7:0] t;
    n = r;
    c = 1'b0;
    h = r[31:24];
    t = 8'h00;
    if (r[7:0] == 8'h99) begin
      n[7:0] = 8'h00;
      c = 1'b1;
    end else begin
      n[7:0] = pcs_bcd_inc(r[7:0]);
    end
    if (c) begin
      c = (r[15:8] == 8'h59);
      n[15:8] = c ? 8'h00 : pcs_bcd_inc(r[15:8]);
    end
    if (c) begin
      c = (r[23:16] == 8'h59);
      n[23:16] = c ? 8'h00 : pcs_bcd_inc(r[23:16]);
    end
    if (c) begin
      if (h[pcs_pkg::HOUR_MODE_BIT]) begin
        // 12-hour: 11 PM to 12 AM carries into the date
        t = pcs_bcd_inc({3'h0, h[4:0]});
        c = (h[4:0] == 5'h11) & h[pcs_pkg::HOUR_PM_BIT];
        if (h[4:0] == 5'h12) begin
          n[28:24] = 5'h01;
        end else if (h[4:0] == 5'h11) begin
          n[28:24] = 5'h12;
          n[24 + pcs_pkg::HOUR_PM_BIT] = ~h[pcs_pkg::HOUR_PM_BIT];
        end else begin
          n[28:24] = t[4:0];
        end
      end else begin
        // 24-hour: bit 5 is the second tens bit
        t = pcs_bcd_inc({2'h0, h[5:0]});
        c = (h[5:0] == 6'h23);
        n[29:24] = c ? 6'h00 : t[5:0];
      end
    end
    if (c) begin
      n[34:32] = (r[34:32] == 3'h7) ? 3'h1 : r[34:32] + 3'h1;
      c = (r[47:40] == pcs_days(r[55:48], r[63:56]));
      n[47:40] = c ? 8'h01 : pcs_bcd_inc(r[47:40]);
    end
    if (c) begin
      c = (r[55:48] == 8'h12);
      n[55:48] = c ? 8'h01 : pcs_bcd_inc(r[55:48]);
    end
    if (c) begin
      n[63:56] = (r[63:56] == 8'h99) ? 8'h00 : pcs_bcd_inc(r[63:56]);
    end
    return n;
  endfunction

  logic [4:0] pins;
  logic strobe;
  logic cyc_end;
  logic ext_abort;
  logic [7:0] wbits;
  logic osc_on;

  assign pins = {link.ext_reset_n, link.serial_data_in_line,
                 link.write_read_select, link.oe_n, link.ce_n};
  assign strobe = ~st_ff.s2[0] & ~st_ff.s2[1];
  assign cyc_end = st_ff.act & ~strobe;
  assign ext_abort =
    ~st_ff.regs[pcs_pkg::DAY_BYTE * 8 + pcs_pkg::RST_MASK_BIT]
    & ~st_ff.s2[4];
  assign osc_on = ~st_ff.regs[pcs_pkg::DAY_BYTE * 8 + pcs_pkg::OSC_STOP_BIT];

  always_comb begin
    nxt_st = st_ff;
    wbits = 8'h00;
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.act = strobe;
    nxt_st.dout = st_ff.shadow[st_ff.cnt];
    // Direction and data are held from the last strobe sample
    if (strobe) begin
      nxt_st.wr = ~st_ff.s2[2];
      nxt_st.din = st_ff.s2[3];
    end
    // Timekeeping only while the oscillator runs
    if (osc_tick & osc_on) begin
      nxt_st.regs = pcs_advance(st_ff.regs);
    end
    if (ext_abort) begin
      // Abort leaves the clock registers as they are
      nxt_st.open = 1'b0;
      nxt_st.ptr = 6'h00;
      nxt_st.miss = 1'b0;
      nxt_st.cnt = 6'h00;
      nxt_st.wbyte = 1'b0;
    end else if (cyc_end & ~st_ff.open) begin
      if (~st_ff.wr) begin
        nxt_st.ptr = 6'h00;
        nxt_st.miss = 1'b0;
      end else if (~st_ff.miss) begin
        if (st_ff.din != pcs_pkg::UNLOCK_PATTERN[st_ff.ptr]) begin
          nxt_st.miss = 1'b1;
        end else if (st_ff.ptr == pcs_pkg::LAST_BIT) begin
          // Snapshot so reads see one coherent time
          nxt_st.open = 1'b1;
          nxt_st.cnt = 6'h00;
          nxt_st.shadow = st_ff.regs;
          nxt_st.ptr = 6'h00;
        end else begin
          nxt_st.ptr = st_ff.ptr + 6'h01;
        end
      end
    end else if (cyc_end) begin
      // Bits step register 0 bit 0 up to register 7 bit 7
      if (st_ff.wr) begin
        nxt_st.shadow[st_ff.cnt] = st_ff.din;
        nxt_st.wbyte = 1'b1;
      end
      if (st_ff.cnt[2:0] == 3'h7) begin
        // Commit whole bytes only; unused bits are forced to zero
        nxt_st.wbyte = 1'b0;
        if (st_ff.wbyte | st_ff.wr) begin
          wbits = nxt_st.shadow[{st_ff.cnt[5:3], 3'h0} +: 8];
          nxt_st.regs[{st_ff.cnt[5:3], 3'h0} +: 8] =
            wbits & pcs_pkg::ZERO_MASK[{st_ff.cnt[5:3], 3'h0} +: 8];
        end
      end
      nxt_st.cnt = st_ff.cnt + 6'h01;
      if (st_ff.cnt == pcs_pkg::LAST_BIT) begin
        nxt_st.open = 1'b0;
        nxt_st.ptr = 6'h00;
        nxt_st.miss = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{s1: 5'h1F, s2: 5'h1F, act: 1'b0, wr: 1'b0, din: 1'b0,
                 ptr: 6'h00, miss: 1'b0, open: 1'b0, cnt: 6'h00,
                 wbyte: 1'b0, dout: 1'b0,
                 regs: pcs_pkg::CLK_REGS_RST,
                 shadow: 64'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Read transfers drive data bit 0 while the strobe is low
  assign link.serial_data_out_o = st_ff.dout;
  assign link.serial_data_out_oe = st_ff.open & strobe & st_ff.s2[2];
  // Write-protect on power fail; memory off while unlocked
  assign mem_ce_n = power_fail_threshold | st_ff.open | link.ce_n;
  assign osc_run = osc_on;
endmodule

// *** pcs_pkg.sv ***
package pcs_pkg;
  // Timing of one bus cycle at 125 MHz
  localparam int CLK_NS = 8;
  localparam int T_SETUP_NS = 20;
  localparam int T_STROBE_NS = 75;
  localparam int T_RECOV_NS = 15;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RECOV_CYC = 4'((T_RECOV_NS + CLK_NS - 1) / CLK_NS);

  // Unlock sequence, byte 0 in the low bits, each byte sent LSB first
  localparam logic [63:0] UNLOCK_PATTERN = 64'h5CA33AC55CA33AC5;
  localparam logic [5:0] LAST_BIT = 6'h3F;
  localparam logic [7:0] FLUSH_LEN = 8'h40;
  localparam logic [7:0] SEQ_LEN = 8'h81;
  localparam logic [7:0] XFER_FIRST = 8'h41;

  // Clock register bytes and fields
  localparam int HOUR_BYTE = 3;
  localparam int DAY_BYTE = 4;
  localparam int HOUR_MODE_BIT = 7;
  localparam int HOUR_PM_BIT = 5;
  localparam int RST_MASK_BIT = 4;
  localparam int OSC_STOP_BIT = 5;
  localparam logic [63:0] CLK_REGS_RST = 64'h0001013100000000;
  localparam logic [63:0] ZERO_MASK = 64'hFF1F3F37BF7F7FFF;

  // Host register map over APB
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WDATA_LO_OFS = 8'h08;
  localparam logic [7:0] WDATA_HI_OFS = 8'h0C;
  localparam logic [7:0] RDATA_LO_OFS = 8'h10;
  localparam logic [7:0] RDATA_HI_OFS = 8'h14;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RST_BIT = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  typedef enum logic [1:0] {
    PCS_OP_FLUSH = 2'b00,
    PCS_OP_READ = 2'b01,
    PCS_OP_WRITE = 2'b10
  } pcs_op_e;

  typedef enum logic [1:0] {
    PCS_H_IDLE = 2'b00,
    PCS_H_SETUP = 2'b01,
    PCS_H_STROBE = 2'b10,
    PCS_H_RECOV = 2'b11
  } pcs_hst_e;
endpackage

// *** pcs_link_if.sv ***
interface pcs_link_if;
  logic ce_n;
  logic oe_n;
  logic write_read_select;
  logic serial_data_in_line;
  logic ext_reset_n;
  logic serial_data_out_o;
  logic serial_data_out_oe;
  logic serial_data_out_line;

  // Undriven line is read as low
  assign serial_data_out_line = serial_data_out_oe & serial_data_out_o;

  modport dev (
    input ce_n, oe_n, write_read_select, serial_data_in_line, ext_reset_n,
    output serial_data_out_o, serial_data_out_oe
  );
  modport host (
    output ce_n, oe_n, write_read_select, serial_data_in_line, ext_reset_n,
    input serial_data_out_line
  );
endinterface

// *** pcs_host.sv ***
module pcs_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Socket link
  pcs_link_if.host link
);
  typedef struct packed {
    pcs_pkg::pcs_hst_e fsm;
    pcs_pkg::pcs_op_e op;
    logic [3:0] tmr;
    logic [7:0] idx;
    logic wr;
    logic ce_n;
    logic wrs;
    logic sdi;
    logic rst_drv;
    logic done;
    logic [1:0] dsync;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic [31:0] prdata;
    logic slverr;
  } pcs_host_s;

  pcs_host_s st_ff;
  pcs_host_s nxt_st;

  // Cycle kind and bit for step n: {write, data}
  function automatic logic [1:0] pcs_step(input pcs_pkg::pcs_op_e op,
                                          input logic [7:0] n,
                                          input logic [63:0] wd);
    logic [7:0] k;
    k = 8'h00;
    if (op == pcs_pkg::PCS_OP_FLUSH || n == 8'h00) begin
      return 2'b00;
    end
    if (n < pcs_pkg::XFER_FIRST) begin
      k = n - 8'h01;
      return {1'b1, pcs_pkg::UNLOCK_PATTERN[k[5:0]]};
    end
    k = n - pcs_pkg::XFER_FIRST;
    // Always all 64 bits, so every byte is whole
    return {op == pcs_pkg::PCS_OP_WRITE, wd[k[5:0]]};
  endfunction

  logic setup_ph;
  logic [1:0] step;
  logic [7:0] last;
  logic [7:0] k;

  assign setup_ph = psel & ~penable;

  always_comb begin
    nxt_st = st_ff;
    step = pcs_step(st_ff.op, st_ff.idx, st_ff.wdata);
    last = (st_ff.op == pcs_pkg::PCS_OP_FLUSH) ? pcs_pkg::FLUSH_LEN
                                                : pcs_pkg::SEQ_LEN;
    k = st_ff.idx - pcs_pkg::XFER_FIRST;
    nxt_st.dsync = {st_ff.dsync[0], link.serial_data_out_line};
    nxt_st.tmr = (st_ff.tmr == 4'h0) ? 4'h0 : st_ff.tmr - 4'h1;
    case (st_ff.fsm)
      pcs_pkg::PCS_H_IDLE: begin
        nxt_st.idx = 8'h00;
      end
      pcs_pkg::PCS_H_SETUP: begin
        nxt_st.wr = step[1];
        nxt_st.wrs = ~step[1];
        nxt_st.sdi = step[0];
        if (st_ff.tmr == 4'h0) begin
          nxt_st.fsm = pcs_pkg::PCS_H_STROBE;
          nxt_st.ce_n = 1'b0;
          nxt_st.tmr = pcs_pkg::STROBE_CYC - 4'h1;
        end
      end
      pcs_pkg::PCS_H_STROBE: begin
        if (st_ff.tmr == 4'h0) begin
          nxt_st.fsm = pcs_pkg::PCS_H_RECOV;
          nxt_st.ce_n = 1'b1;
          nxt_st.tmr = pcs_pkg::RECOV_CYC - 4'h1;
          if (~st_ff.wr && st_ff.idx >= pcs_pkg::XFER_FIRST) begin
            nxt_st.rdata[k[5:0]] = st_ff.dsync[1];
          end
        end
      end
      pcs_pkg::PCS_H_RECOV: begin
        if (st_ff.tmr == 4'h0) begin
          nxt_st.idx = st_ff.idx + 8'h01;
          nxt_st.tmr = pcs_pkg::SETUP_CYC - 4'h1;
          nxt_st.fsm = (st_ff.idx + 8'h01 == last) ? pcs_pkg::PCS_H_IDLE
                                                   : pcs_pkg::PCS_H_SETUP;
          nxt_st.done = (st_ff.idx + 8'h01 == last) | st_ff.done;
        end
      end
      default: nxt_st.fsm = pcs_pkg::PCS_H_IDLE;
    endcase
    if (setup_ph) begin
      nxt_st.slverr = 1'b0;
      case (paddr)
        pcs_pkg::CTRL_OFS: nxt_st.prdata = {28'h0, st_ff.rst_drv, st_ff.op,
                                            1'b0};
        pcs_pkg::STATUS_OFS: nxt_st.prdata = {30'h0, st_ff.done,
                                  st_ff.fsm != pcs_pkg::PCS_H_IDLE};
        pcs_pkg::WDATA_LO_OFS: nxt_st.prdata = st_ff.wdata[31:0];
        pcs_pkg::WDATA_HI_OFS: nxt_st.prdata = st_ff.wdata[63:32];
        pcs_pkg::RDATA_LO_OFS: nxt_st.prdata = st_ff.rdata[31:0];
        pcs_pkg::RDATA_HI_OFS: nxt_st.prdata = st_ff.rdata[63:32];
        default: begin
          nxt_st.prdata = 32'h0;
          nxt_st.slverr = 1'b1;
        end
      endcase
    end
    if (psel & penable & pwrite) begin
      case (paddr)
        pcs_pkg::CTRL_OFS: begin
          nxt_st.rst_drv = pwdata[pcs_pkg::CTRL_RST_BIT];
          // A start while busy is ignored
          if (pwdata[pcs_pkg::CTRL_GO_BIT] &&
              st_ff.fsm == pcs_pkg::PCS_H_IDLE) begin
            nxt_st.op = pcs_pkg::pcs_op_e'(pwdata[2:1]);
            nxt_st.fsm = pcs_pkg::PCS_H_SETUP;
            nxt_st.tmr = pcs_pkg::SETUP_CYC - 4'h1;
            nxt_st.idx = 8'h00;
          end
        end
        pcs_pkg::STATUS_OFS: begin
          // Completion in the same cycle keeps the flag set
          if (pwdata[pcs_pkg::STAT_DONE_BIT] &
              ~(nxt_st.done & ~st_ff.done)) begin
            nxt_st.done = 1'b0;
          end
        end
        pcs_pkg::WDATA_LO_OFS: nxt_st.wdata[31:0] = pwdata;
        pcs_pkg::WDATA_HI_OFS: nxt_st.wdata[63:32] = pwdata;
        default: nxt_st.done = nxt_st.done;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{fsm: pcs_pkg::PCS_H_IDLE, op: pcs_pkg::PCS_OP_FLUSH,
                 tmr: 4'h0, idx: 8'h00, wr: 1'b0, ce_n: 1'b1, wrs: 1'b1,
                 sdi: 1'b0, rst_drv: 1'b0, done: 1'b0, dsync: 2'h0,
                 wdata: 64'h0, rdata: 64'h0, prdata: 32'h0, slverr: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.slverr;
  assign pready = 1'b1;
  assign link.ce_n = st_ff.ce_n;
  assign link.oe_n = st_ff.ce_n;
  assign link.write_read_select = st_ff.wrs;
  assign link.serial_data_in_line = st_ff.sdi;
  assign link.ext_reset_n = ~st_ff.rst_drv;
endmodule

// *** pcs_link_props.sv ***
module pcs_link_props (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Socket link
  input logic ce_n,
  input logic oe_n,
  input logic write_read_select,
  input logic serial_data_out_o,
  input logic serial_data_out_oe,
  // Socket side
  input logic power_fail_threshold,
  input logic mem_ce_n,
  input logic osc_run
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_pf_mem_off;
    power_fail_threshold |-> mem_ce_n;
  endproperty
  a_pf_mem_off: assert property (p_pf_mem_off)
    else $error("memory enabled during power fail");

  property p_mem_follow;
    !mem_ce_n |-> !ce_n && !power_fail_threshold;
  endproperty
  a_mem_follow: assert property (p_mem_follow)
    else $error("memory enabled without socket enable");

  property p_out_read_only;
    serial_data_out_oe |-> write_read_select;
  endproperty
  a_out_read_only: assert property (p_out_read_only)
    else $error("data line driven on a write cycle");

  property p_out_mem_off;
    serial_data_out_oe |-> mem_ce_n;
  endproperty
  a_out_mem_off: assert property (p_out_mem_off)
    else $error("memory enabled while clock drives data");

  property p_out_in_strobe;
    $rose(serial_data_out_oe) |-> !ce_n && !oe_n;
  endproperty
  a_out_in_strobe: assert property (p_out_in_strobe)
    else $error("data line driven outside a strobe");

  property p_out_release;
    ce_n [*5] |-> !serial_data_out_oe;
  endproperty
  a_out_release: assert property (p_out_release)
    else $error("data line not released after strobe");

  property p_out_steady;
    serial_data_out_oe && $past(serial_data_out_oe)
      |-> $stable(serial_data_out_o);
  endproperty
  a_out_steady: assert property (p_out_steady)
    else $error("read bit changed within a cycle");

  property p_osc_in_xfer;
    !$stable(osc_run) |-> mem_ce_n;
  endproperty
  a_osc_in_xfer: assert property (p_osc_in_xfer)
    else $error("oscillator control changed outside a transfer");
endmodule

// *** pcs_tb.sv ***
module pcs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic power_fail_threshold = 1'b0;
  logic osc_tick = 1'b0;
  logic tick_en = 1'b1;
  logic [7:0] tick_cnt = 8'h00;
  logic mem_ce_n;
  logic osc_run;
  logic [31:0] rd;
  logic err;
  logic [63:0] v;
  int fails = 0;
  int num_checks = 0;
  // Unused bits set on purpose; day byte of w1 masks reset, w2 does not
  logic [63:0] w1 = 64'h2412_3113_2359_D800;
  logic [63:0] w2 = 64'h9981_2802_B112_3045;
  // One tick past 11:59:59.99 PM, day 7, 28 Feb of a leap year
  logic [63:0] w3 = 64'h0002_2817_B159_5999;
  logic [63:0] w3_next = 64'h0002_2911_9200_0000;

  always #4 clk = ~clk;

  pcs_link_if link_if();

  pcs_device pcs_device_inst (
    .clk(clk),
    .rst_n(rst_n),
    .link(link_if),
    .power_fail_threshold(power_fail_threshold),
    .osc_tick(osc_tick),
    .mem_ce_n(mem_ce_n),
    .osc_run(osc_run)
  );

  pcs_host pcs_host_inst (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link(link_if)
  );

  pcs_link_props pcs_link_props_inst (
    .clk(clk),
    .rst_n(rst_n),
    .ce_n(link_if.ce_n),
    .oe_n(link_if.oe_n),
    .write_read_select(link_if.write_read_select),
    .serial_data_out_o(link_if.serial_data_out_o),
    .serial_data_out_oe(link_if.serial_data_out_oe),
    .power_fail_threshold(power_fail_threshold),
    .mem_ce_n(mem_ce_n),
    .osc_run(osc_run)
  );

  // Ticks while the oscillator is stopped must not move the time
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 8'h01;
    osc_tick <= tick_en && (tick_cnt == 8'h00);
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fails++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd64(output logic [63:0] r);
    apb(1'b0, pcs_pkg::RDATA_LO_OFS, 32'h0);
    r[31:0] = rd;
    apb(1'b0, pcs_pkg::RDATA_HI_OFS, 32'h0);
    r[63:32] = rd;
  endtask

  // One whole socket sequence; pulse drops the reset pin mid-transfer
  task automatic do_op(input logic [1:0] op, input logic [63:0] wd,
                       input logic pulse);
    int i;
    int n;
    logic prev;
    n = 0;
    prev = 1'b1;
    apb(1'b1, pcs_pkg::WDATA_LO_OFS, wd[31:0]);
    apb(1'b1, pcs_pkg::WDATA_HI_OFS, wd[63:32]);
    apb(1'b1, pcs_pkg::CTRL_OFS, {29'h0, op, 1'b1});
    apb(1'b0, pcs_pkg::STATUS_OFS, 32'h0);
    chk({32'h0, rd}, 64'h1);
    // First strobe; with pulse, 65 strobes to unlock and two transfers
    for (i = 0; i < 3000 && n < (pulse ? 67 : 1); i++) begin
      @(negedge clk);
      if (prev && !link_if.ce_n) begin
        n++;
        if (n == 1) begin
          // Locked cycles reach memory unless power has failed
          chk({63'h0, mem_ce_n}, {63'h0, power_fail_threshold});
        end
        if (n == 67) begin
          chk({63'h0, mem_ce_n}, 64'h1);
        end
      end
      prev = link_if.ce_n;
    end
    if (pulse) begin
      apb(1'b1, pcs_pkg::CTRL_OFS, {28'h0, 1'b1, op, 1'b0});
      apb(1'b1, pcs_pkg::CTRL_OFS, {29'h0, op, 1'b0});
    end
    rd = 32'h0;
    for (i = 0; i < 2000 && rd[pcs_pkg::STAT_DONE_BIT] !== 1'b1; i++) begin
      apb(1'b0, pcs_pkg::STATUS_OFS, 32'h0);
    end
    if (rd[pcs_pkg::STAT_DONE_BIT] !== 1'b1) begin
      fails++;
      end_sim();
    end
    apb(1'b1, pcs_pkg::STATUS_OFS, 32'h2);
    apb(1'b0, pcs_pkg::STATUS_OFS, 32'h0);
    chk({32'h0, rd}, 64'h0);
  endtask

  initial begin
    int i;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, pcs_pkg::STATUS_OFS, 32'h0);
    chk({32'h0, rd}, 64'h0);
    chk({63'h0, osc_run}, 64'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err, rd}, {31'h0, 1'b1, 32'h0});
    power_fail_threshold <= 1'b1;
    do_op(pcs_pkg::PCS_OP_FLUSH, 64'h0, 1'b0);
    power_fail_threshold <= 1'b0;
    do_op(pcs_pkg::PCS_OP_READ, 64'h0, 1'b0);
    rd64(v);
    chk(v, pcs_pkg::CLK_REGS_RST);
    tick_en <= 1'b0;
    do_op(pcs_pkg::PCS_OP_WRITE, w1, 1'b0);
    chk({63'h0, osc_run}, 64'h1);
    do_op(pcs_pkg::PCS_OP_READ, 64'h0, 1'b0);
    rd64(v);
    chk(v, w1 & pcs_pkg::ZERO_MASK);
    do_op(pcs_pkg::PCS_OP_WRITE, w3, 1'b0);
    // Let exactly one tick through while the oscillator runs
    tick_en <= 1'b1;
    for (i = 0; i < 300 && osc_tick !== 1'b1; i++) begin
      @(negedge clk);
    end
    @(posedge clk);
    tick_en <= 1'b0;
    do_op(pcs_pkg::PCS_OP_READ, 64'h0, 1'b0);
    rd64(v);
    chk(v, w3_next);
    do_op(pcs_pkg::PCS_OP_WRITE, w2, 1'b1);
    do_op(pcs_pkg::PCS_OP_WRITE, 64'h0, 1'b1);
    do_op(pcs_pkg::PCS_OP_READ, 64'h0, 1'b0);
    rd64(v);
    chk(v, w2 & pcs_pkg::ZERO_MASK);
    end_sim();
  end
endmodule
